// ### dv/tccr_host_model.sv
// Host side model that issues commands and collects answers
`timescale 1ns/1ns
module tccr_host_model
  import tccr_pkg::*;
(
  // Clock
  input  wire logic      ref_clk,
  // Command port
  output tccr_cmd_t      cmd,
  input  wire tccr_rsp_t rsp_q
);
  ////////////////////////////////////////////////////////////
  // Idle until the first command
  initial cmd = '0;

  // One command; released fields carry junk so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] code, page, input logic [15:0] wd,
                      output tccr_rsp_t r, output bit ok);
    ok = 1'b0;
    @(negedge ref_clk);
    cmd = '{valid:1'b1, write:w, code:code, page:page, wdata:wd};
    @(negedge ref_clk);
    cmd = '{valid:1'b0, write:~w, code:~code, page:~page, wdata:~wd};
    // The answer stands only from the taking edge to the next, so look at each falling edge
    repeat (4)
    begin
      if (rsp_q.valid === 1'b1 && !ok)
      begin
        r = rsp_q;
        ok = 1'b1;
      end
      if (!ok)
        @(negedge ref_clk);
    end
  endtask : xfer
endmodule : tccr_host_model

// ### dv/tccr_top_props.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
`include "tccr_defs.svh"
module tccr_top_props
  import tccr_pkg::*;
#(
  parameter int         NUM_CH        = 8,
  parameter logic [7:0] REVISION_CODE = 8'h5A  // Arbitrary value
)
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // Command port
  input wire tccr_cmd_t         cmd,
  input wire tccr_rsp_t         rsp_q,
  // Channel side
  input wire tccr_chcfg_t       chan_cfg_q [NUM_CH],
  input wire logic [NUM_CH-1:0] reservo_q
);
  ////////////////////////////////////////////////////////////
  // All checks share the one clock, and reset masks them
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_ANSWER: assert property (cmd.valid |=> rsp_q.valid)
    else $error("no answer one cycle after a command");
  AST_NO_SPUR: assert property (rsp_q.valid |-> $past(cmd.valid))
    else $error("answer without a command");
  AST_REV: assert property (cmd.valid && !cmd.write && cmd.code == `TCCR_CMD_REV
    |=> !rsp_q.err && rsp_q.rdata == {8'h00, REVISION_CODE}) else $error("revision read wrong");
  AST_RO_WRITE: assert property (cmd.valid && cmd.write && cmd.code == `TCCR_CMD_REV
    |=> rsp_q.err && rsp_q.rdata == 16'h0000) else $error("revision write not refused");
  AST_RSVD: assert property (cmd.valid && !cmd.write && cmd.code == `TCCR_CMD_CFG
    |=> rsp_q.rdata[13:12] == 2'h0) else $error("reserved bits not zero");
  AST_EVEN_LOWRES: assert property (!chan_cfg_q[0].adc_hires && !chan_cfg_q[2].adc_hires)
    else $error("even channel in fine resolution");
  AST_CONT: assert property (chan_cfg_q[3].servo_cont |-> chan_cfg_q[3].dac_mode == 2'h0)
    else $error("continuous servo outside servo mode");
  AST_WARN_GATE: assert property (chan_cfg_q[3].servo_on_warn
    |-> chan_cfg_q[3].dac_mode == 2'h0 && !chan_cfg_q[3].servo_cont) else $error("warn servo gate");
  AST_RESERVO: assert property (reservo_q[3]
    |-> $past(chan_cfg_q[3].servo_on_warn) && !$past(reservo_q[3])) else $error("bad re-servo pulse");
endmodule : tccr_top_props

bind tccr_top tccr_top_props #(.NUM_CH(NUM_CH), .REVISION_CODE(REVISION_CODE)) u_props
  (.ref_clk, .rst, .cmd, .rsp_q, .chan_cfg_q, .reservo_q);

// ### dv/tccr_top_tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/1ns
`include "tccr_defs.svh"
module tccr_top_tb_top
  import tccr_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  tccr_cmd_t   cmd;
  tccr_rsp_t   rsp_q;
  tccr_adc_t   adc;
  logic        first_control_pin;
  logic        second_control_pin;
  logic [7:0]  ov_warn_hit;
  logic [7:0]  uv_warn_hit;
  tccr_chcfg_t chan_cfg_q [8];
  logic [7:0]  chan_control_q;
  logic [7:0]  reservo_q;
  logic [7:0]  vout_l11_mv_q;
  int          n_fail;
  int          compares;

  ////////////////////////////////////////////////////////////
  // Design and host model
  tccr_top #(.NUM_CH(8)) dut (.ref_clk, .rst, .cmd, .rsp_q, .adc, .first_control_pin,
    .second_control_pin, .ov_warn_hit, .uv_warn_hit, .chan_cfg_q, .chan_control_q,
    .reservo_q, .vout_l11_mv_q);
  tccr_host_model u_host (.ref_clk, .cmd, .rsp_q);

  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [16:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One command; expected value is {err, rdata}
  task automatic op(input logic w, input logic [7:0] code, page, input logic [15:0] wd,
                    input logic [16:0] exp);
    tccr_rsp_t r;
    bit        ok;
    u_host.xfer(w, code, page, wd, r, ok);
    if (!ok)
    begin
      chk(17'h00000, 17'h00001);
      results();
    end
    else
      chk({r.err, r.rdata}, exp);
  endtask : op

  // Config write, then let the decoded settings land
  task automatic cfg(input logic [7:0] p, input logic [15:0] d);
    op(1'b1, `TCCR_CMD_CFG, p, d, 17'h00000);
    repeat (2) @(negedge ref_clk);
  endtask : cfg

  task automatic conv(input tccr_src_t s, input logic [7:0] ch, input logic [15:0] w);
    @(negedge ref_clk);
    adc = '{valid:1'b1, src:s, chan:ch, word:w};
    @(negedge ref_clk);
    adc = '{valid:1'b0, src:s, chan:~ch, word:~w};
  endtask : conv

  // Apply a warning on channel 3 and count re-servo pulses
  task automatic warn(input logic o, u, input logic [16:0] exp);
    logic [16:0] c;
    c = 17'h00000;
    ov_warn_hit[3] = o;
    uv_warn_hit[3] = u;
    repeat (5)
    begin
      @(negedge ref_clk);
      c = c + 17'(reservo_q[3]);
    end
    ov_warn_hit = 8'h00;
    uv_warn_hit = 8'h00;
    repeat (2) @(negedge ref_clk);
    chk(c, exp);
  endtask : warn

  // Main sequence
  initial
  begin
    n_fail = 0;
    compares = 0;
    rst = 1'b1;
    adc = '0;
    first_control_pin = 1'b0;
    second_control_pin = 1'b1;
    ov_warn_hit = 8'h00;
    uv_warn_hit = 8'h00;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    op(1'b0, `TCCR_CMD_REV, 8'h00, 16'h0000, {1'b0, 8'h00, 8'h5A});
    op(1'b1, `TCCR_CMD_REV, 8'h00, 16'h1234, 17'h10000);
    op(1'b0, `TCCR_CMD_REV, 8'h00, 16'h0000, {1'b0, 8'h00, 8'h5A});
    cfg(8'h03, 16'hFFFF);
    op(1'b0, `TCCR_CMD_CFG, 8'h03, 16'h0000, 17'h0CFFF);
    conv(TCCR_SRC_VIN, 8'h00, 16'h1234);
    op(1'b0, `TCCR_CMD_VIN, 8'h00, 16'h0000, 17'h01234);
    op(1'b0, `TCCR_CMD_VIN, 8'h00, 16'h0000, 17'h01234);
    conv(TCCR_SRC_TEMP, 8'h00, 16'hBEEF);
    op(1'b0, `TCCR_CMD_TEMP, 8'h00, 16'h0000, 17'h0BEEF);
    cfg(8'h01, 16'h0200);
    chk(17'(chan_cfg_q[1].adc_hires), 17'h00001);
    conv(TCCR_SRC_VOUT, 8'h01, 16'hA5C3);
    op(1'b0, `TCCR_CMD_VOUT, 8'h01, 16'h0000, 17'h0A5C3);
    chk(17'(vout_l11_mv_q[1]), 17'h00001);
    cfg(8'h02, 16'h0200);
    conv(TCCR_SRC_VOUT, 8'h02, 16'h5A3C);
    op(1'b0, `TCCR_CMD_VOUT, 8'h02, 16'h0000, 17'h05A3C);
    op(1'b0, `TCCR_CMD_VOUT, 8'h08, 16'h0000, 17'h10000);
    chk(17'(vout_l11_mv_q[2]), 17'h00000);
    for (int m = 0; m < 4; m++)
    begin
      cfg(8'h03, {m[1:0], 14'h0000});
      chk(17'({chan_cfg_q[3].track_slave, chan_cfg_q[3].seq_off_on_fault}), 17'(m[1] ? 2'h2 : {1'b0, m[0]}));
    end
    cfg(8'h03, 16'h0F00);
    chk(17'({chan_cfg_q[3].fast_servo_en, chan_cfg_q[3].sup_low_res}), 17'h00001);
    repeat (4) @(negedge ref_clk);
    chk(17'(chan_control_q[3]), 17'h00001);
    // Pin change must pass the synchroniser and reach the selected channel
    second_control_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(17'(chan_control_q[3]), 17'h00000);
    second_control_pin = 1'b1;
    cfg(8'h03, 16'h0000);
    repeat (4) @(negedge ref_clk);
    chk(17'({chan_control_q[3], chan_cfg_q[3].fast_servo_en, chan_cfg_q[3].sup_low_res}), 17'h00002);
    cfg(8'h03, 16'h00C0);
    chk(17'({chan_cfg_q[3].servo_cont, chan_cfg_q[3].servo_on_warn}), 17'h00002);
    cfg(8'h03, 16'h00D0);
    chk(17'({chan_cfg_q[3].servo_cont, chan_cfg_q[3].servo_on_warn}), 17'h00000);
    chk(17'(chan_cfg_q[3].dac_mode), 17'h00001);
    cfg(8'h03, 16'h0040);
    chk(17'({chan_cfg_q[3].servo_cont, chan_cfg_q[3].servo_on_warn}), 17'h00001);
    warn(1'b1, 1'b0, 17'h00001);
    warn(1'b0, 1'b1, 17'h00001);
    cfg(8'h03, 16'h0000);
    warn(1'b1, 1'b0, 17'h00000);
    results();
  end
endmodule : tccr_top_tb_top

// ### hdl/tccr_chan.sv
// One channel: configuration word storage, decode and re-servo trigger
`timescale 1ns/1ns
`include "tccr_defs.svh"
module tccr_chan
  import tccr_pkg::*;
#(
  parameter bit ODD = 1'b0
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Configuration write
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  // Synchronised control pins, bit 0 first, bit 1 second
  input  wire logic [1:0]  ctrl_sync,
  // Warning comparisons from the supervisor
  input  wire logic        ov_hit,
  input  wire logic        uv_hit,
  // Results
  output logic      [15:0] cfg_word_q,
  output tccr_chcfg_t      cfg_q,
  output logic             control_q,
  output logic             reservo_q
);

  tccr_chcfg_t cfg_d;
  logic        servo_mode;
  logic        warn_q;

  // Store the word; reserved bits are dropped so they read back as zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg_word_q <= `TCCR_CFG_RST;
    else if (wr_en)
      cfg_word_q <= wdata & `TCCR_CFG_WMASK;
  end

  assign servo_mode = (cfg_word_q[`TCCR_CFG_DAC_HI:`TCCR_CFG_DAC_LO] == `TCCR_DAC_SERVO);

  // Decode fields into effective settings
  always_comb
  begin
    cfg_d                  = '0;
    cfg_d.track_slave      = cfg_word_q[`TCCR_CFG_MODE_HI];
    cfg_d.seq_off_on_fault = ~cfg_word_q[`TCCR_CFG_MODE_HI] & cfg_word_q[`TCCR_CFG_MODE_LO];
    cfg_d.fast_servo_en    = ~cfg_word_q[`TCCR_CFG_FAST_OFF];
    cfg_d.sup_low_res      = cfg_word_q[`TCCR_CFG_SUP_LOWRES];
    // Even channels always convert at low resolution
    cfg_d.adc_hires        = ODD & cfg_word_q[`TCCR_CFG_ADC_HIRES];
    cfg_d.servo_cont       = servo_mode & cfg_word_q[`TCCR_CFG_SERVO_CONT];
    cfg_d.servo_on_warn    = servo_mode & ~cfg_word_q[`TCCR_CFG_SERVO_CONT]
                             & cfg_word_q[`TCCR_CFG_SERVO_WARN];
    cfg_d.dac_mode         = cfg_word_q[`TCCR_CFG_DAC_HI:`TCCR_CFG_DAC_LO];
  end

  // Register decoded settings so every output is a flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg_q <= '0;
    else
      cfg_q <= cfg_d;
  end

  // Pick the governing control pin
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      control_q <= 1'b0;
    else
      control_q <= cfg_word_q[`TCCR_CFG_CTRL_SEL] ? ctrl_sync[1] : ctrl_sync[0];
  end

  // One pulse per entry into a warning; a held warning does not re-trigger
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      warn_q    <= 1'b0;
      reservo_q <= 1'b0;
    end
    else
    begin
      warn_q    <= ov_hit | uv_hit;
      reservo_q <= cfg_q.servo_on_warn & (ov_hit | uv_hit) & ~warn_q;
    end
  end

endmodule : tccr_chan

// ### hdl/tccr_defs.svh
// Constants for the telemetry and channel configuration register bank
`ifndef TCCR_DEFS_SVH
`define TCCR_DEFS_SVH

// Command codes seen on the command port from the transaction layer
`define TCCR_CMD_VIN        8'h88
`define TCCR_CMD_VOUT       8'h8B
`define TCCR_CMD_TEMP       8'h8D
`define TCCR_CMD_REV        8'h98
`define TCCR_CMD_CFG        8'hD0

// Configuration word field positions
`define TCCR_CFG_MODE_HI    15
`define TCCR_CFG_MODE_LO    14
`define TCCR_CFG_FAST_OFF   11
`define TCCR_CFG_SUP_LOWRES 10
`define TCCR_CFG_ADC_HIRES  9
`define TCCR_CFG_CTRL_SEL   8
`define TCCR_CFG_SERVO_CONT 7
`define TCCR_CFG_SERVO_WARN 6
`define TCCR_CFG_DAC_HI     5
`define TCCR_CFG_DAC_LO     4

// Reserved bits 13:12 are never stored
`define TCCR_CFG_WMASK      16'hCFFF

// DAC mode value that means soft-connect and servo
`define TCCR_DAC_SERVO      2'h0

// Reset values
`define TCCR_CFG_RST        16'h0000
`define TCCR_TELEM_RST      16'h0000
`define TCCR_REV_PAD        8'h00

`endif

// ### hdl/tccr_pkg.sv
// Types shared by the telemetry and channel configuration register bank
package tccr_pkg;

  // Source of an incoming conversion result
  typedef enum logic [1:0] {
    TCCR_SRC_VIN  = 2'h0,
    TCCR_SRC_VOUT = 2'h1,
    TCCR_SRC_TEMP = 2'h3
  } tccr_src_t;

  // Command from the transaction layer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [7:0]  page;
    logic [15:0] wdata;
  } tccr_cmd_t;

  // Answer to the transaction layer
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] rdata;
  } tccr_rsp_t;

  // Finished conversion from the ADC datapath
  typedef struct packed {
    logic        valid;
    tccr_src_t   src;
    logic [7:0]  chan;
    logic [15:0] word;
  } tccr_adc_t;

  // Decoded per-channel settings driven to the channel logic
  typedef struct packed {
    logic       track_slave;
    logic       seq_off_on_fault;
    logic       fast_servo_en;
    logic       sup_low_res;
    logic       adc_hires;
    logic       servo_cont;
    logic       servo_on_warn;
    logic [1:0] dac_mode;
  } tccr_chcfg_t;

endpackage : tccr_pkg

// ### hdl/tccr_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module tccr_sync
  import tccr_pkg::*;
#(
  parameter int W = 2
)
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Pin side
  input  wire logic [W-1:0] async_in,
  // Clock side
  output logic      [W-1:0] sync_q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage, to contain metastability
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule : tccr_sync

// ### hdl/tccr_top.sv
// Telemetry readback and per-channel configuration register bank
`timescale 1ns/1ns
`include "tccr_defs.svh"
module tccr_top
  import tccr_pkg::*;
#(
  parameter int         NUM_CH        = 8,
  parameter logic [7:0] REVISION_CODE = 8'h5A  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Command port from the transaction layer
  input  wire tccr_cmd_t   cmd,
  output tccr_rsp_t        rsp_q,
  // Conversion results from the ADC datapath
  input  wire tccr_adc_t   adc,
  // Asynchronous control pins
  input  wire logic        first_control_pin,
  input  wire logic        second_control_pin,
  // Warning comparisons, one per channel
  input  wire logic [NUM_CH-1:0] ov_warn_hit,
  input  wire logic [NUM_CH-1:0] uv_warn_hit,
  // Per-channel settings and events
  output tccr_chcfg_t      chan_cfg_q     [NUM_CH],
  output logic [NUM_CH-1:0] chan_control_q,
  output logic [NUM_CH-1:0] reservo_q,
  // Format of each stored output reading: high when L11 millivolts
  output logic [NUM_CH-1:0] vout_l11_mv_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]  ctrl_sync;
  logic [15:0] cfg_word [NUM_CH];
  logic [15:0] vin_q;
  logic [15:0] temp_q;
  logic [15:0] vout_q   [NUM_CH];
  logic        page_ok;
  logic [2:0]  page_idx;
  logic        cfg_wr;
  tccr_rsp_t   rsp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Control pin synchroniser

  tccr_sync #(
    .W (2)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({second_control_pin, first_control_pin}),
    .sync_q   (ctrl_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Page decode

  // Pages outside the channel range are refused rather than aliased
  assign page_ok  = (32'(cmd.page) < NUM_CH);
  assign page_idx = cmd.page[2:0];

  // Only a write to the configuration code touches stored settings
  assign cfg_wr = cmd.valid & cmd.write & page_ok & (cmd.code == `TCCR_CMD_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_chan
    logic        sel;
    logic        vout_hit;

    assign sel      = (page_idx == 3'(g));
    assign vout_hit = adc.valid & (adc.src == TCCR_SRC_VOUT) & (adc.chan == 8'(g));

    tccr_chan #(
      .ODD (g % 2 == 1)
    ) u_chan (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .wr_en      (cfg_wr & sel),
      .wdata      (cmd.wdata),
      .ctrl_sync  (ctrl_sync),
      .ov_hit     (ov_warn_hit[g]),
      .uv_hit     (uv_warn_hit[g]),
      .cfg_word_q (cfg_word[g]),
      .cfg_q      (chan_cfg_q[g]),
      .control_q  (chan_control_q[g]),
      .reservo_q  (reservo_q[g])
    );

    // Whole-word capture with its format tag, taken at the conversion
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        vout_q[g]        <= `TCCR_TELEM_RST;
        vout_l11_mv_q[g] <= 1'b0;
      end
      else if (vout_hit)
      begin
        vout_q[g]        <= adc.word;
        vout_l11_mv_q[g] <= chan_cfg_q[g].adc_hires;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared telemetry words

  // Input voltage: replaced whole when a new conversion lands
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      vin_q <= `TCCR_TELEM_RST;
    else if (adc.valid && adc.src == TCCR_SRC_VIN)
      vin_q <= adc.word;
  end

  // Junction temperature: replaced whole when a new conversion lands
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      temp_q <= `TCCR_TELEM_RST;
    else if (adc.valid && adc.src == TCCR_SRC_TEMP)
      temp_q <= adc.word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command answer

  // Reads sample the stored words only, so they disturb nothing
  always_comb
  begin
    rsp_d       = '0;
    rsp_d.valid = cmd.valid;
    if (cmd.valid)
    begin
      case (cmd.code)
        `TCCR_CMD_VIN:
        begin
          rsp_d.err   = cmd.write;
          rsp_d.rdata = cmd.write ? 16'h0000 : vin_q;
        end
        `TCCR_CMD_TEMP:
        begin
          rsp_d.err   = cmd.write;
          rsp_d.rdata = cmd.write ? 16'h0000 : temp_q;
        end
        `TCCR_CMD_REV:
        begin
          // Write is refused and the code stays fixed
          rsp_d.err   = cmd.write;
          rsp_d.rdata = cmd.write ? 16'h0000 : {`TCCR_REV_PAD, REVISION_CODE};
        end
        `TCCR_CMD_VOUT:
        begin
          rsp_d.err = cmd.write | ~page_ok;
          if (!cmd.write && page_ok)
            rsp_d.rdata = vout_q[page_idx];
        end
        `TCCR_CMD_CFG:
        begin
          rsp_d.err = ~page_ok;
          if (!cmd.write && page_ok)
            rsp_d.rdata = cfg_word[page_idx];
        end
        default:
        begin
          rsp_d.err = 1'b1;
        end
      endcase
    end
  end

  // One answer per command, one cycle after it is taken
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rsp_q <= '0;
    else
      rsp_q <= rsp_d;
  end

endmodule : tccr_top
